// *** core/cap_pkg.sv ***
// Constants and carrier types for the counter array PWM block.
// Assumes a byte-wide register port driven by the CPU's SFR space.
`default_nettype none
package cap_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] CTRL0_OFF = 8'h_a4;
    localparam logic [7:0] CNT_LO_OFF = 8'h_a2;
    localparam logic [7:0] CNT_HI_OFF = 8'h_a3;
    localparam logic [7:0] STATUS_OFF = 8'h_a5;
    localparam logic [7:0] MODE0_OFF = 8'h_a9;
    localparam logic [7:0] CMP_LO0_OFF = 8'h_ac;
    localparam logic [7:0] CMP_HI0_OFF = 8'h_ad;
    localparam logic [7:0] CMP_LO1_OFF = 8'h_af;
    localparam logic [7:0] CMP_HI1_OFF = 8'h_b1;
    localparam logic [7:0] CMP_LO2_OFF = 8'h_b2;
    localparam logic [7:0] CMP_HI2_OFF = 8'h_b3;
    localparam logic [7:0] PERIOD_OFF = 8'h_b4;
    // ****************************************************************
    // Control field positions and reset values
    // ****************************************************************
    localparam int CTRL_EN_ALL_BIT = 7;
    localparam int CTRL_RUN_BIT = 6;
    localparam int CTRL_OVF_IE_BIT = 5;
    localparam int CTRL_TEN_BIT = 2;
    localparam int STAT_OVERFLOW_FLAG_BLOCK0_BIT = 3;
    localparam logic [7:0] CTRL_RESET = 8'h_00;
    localparam logic [7:0] CTRL_WMASK = 8'h_f7;
    localparam logic [7:0] MODE_RESET = 8'h_00;
    localparam logic [7:0] STATUS_RESET = 8'h_00;
    localparam logic [15:0] TEN_MASK = 16'h_03ff;
    // Mode register PWM select field, bits 1:0, and compare enable bit 6
    localparam int MODE_ECOMP_BIT = 6;
    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        CAP_PWM_OFF = 2'b00,
        CAP_PWM_X8 = 2'b01,
        CAP_PWM_PROG = 2'b10,
        CAP_PWM_WIDE = 2'b11
    } cap_pwm_t;
    typedef enum logic [1:0] {
        CAP_CLK_PRESC = 2'b00,
        CAP_CLK_T0OVF = 2'b01,
        CAP_CLK_EXT = 2'b10,
        CAP_CLK_NONE = 2'b11
    } cap_clksel_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cap_req_t;
    typedef struct packed {
        logic tick;       // Counter advances this cycle
        logic ten;        // Ten bit select
        logic [15:0] cnt; // Counter value
        logic wrap;       // Counter wraps this cycle
        logic prd_hit;    // Period match this cycle
    } cap_cnt_t;
endpackage : cap_pkg
`default_nettype wire

// *** core/cap_tick_sel.sv ***
// Counter clock source select, producing a one-cycle advance strobe.
// Assumes the source strobes are synchronous single-cycle pulses or levels.
`default_nettype none
module cap_tick_sel (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [1:0] sel,
    input wire logic presc_tick,
    input wire logic t0_ovf,
    input wire logic ext_clk,
    output logic tick
);
    logic ext_d_r;
    logic src;

    // External pin counts on its rising edge; others are already pulses
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_d_r <= 1'b0;
        end else begin
            ext_d_r <= ext_clk;
        end
    end

    // Source select
    always_comb begin
        case (cap_pkg::cap_clksel_t'(sel))
            cap_pkg::CAP_CLK_PRESC: src = presc_tick;
            cap_pkg::CAP_CLK_T0OVF: src = t0_ovf;
            cap_pkg::CAP_CLK_EXT: src = ext_clk & ~ext_d_r;
            default: src = 1'b0;
        endcase
    end

    assign tick = run & src;
endmodule : cap_tick_sel
`default_nettype wire

// *** core/cap_module.sv ***
// One timer/compare module in PWM role: compare regs, enable, output.
// Assumes the shared counter strobes come from the block top.
`default_nettype none
module cap_module (
    input wire logic clk,
    input wire logic rst_n,
    input wire cap_pkg::cap_cnt_t cnt,
    input wire logic [1:0] pwm_mode,
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [7:0] wdata,
    output logic [7:0] cmp_lo,
    output logic [7:0] cmp_hi,
    output logic ecomp,
    output logic pwm_out
);
    logic [7:0] duty_r;
    logic [15:0] cmp16;
    logic hit;
    logic [7:0] cmp_lo_r;
    logic [7:0] cmp_hi_r;
    logic ecomp_r;
    logic out_r;

    assign cmp_lo = cmp_lo_r;
    assign cmp_hi = cmp_hi_r;
    assign ecomp = ecomp_r;
    assign pwm_out = out_r;
    assign cmp16 = {cmp_hi_r, cmp_lo_r};

    // Compare registers; low write disarms, high write arms
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_lo_r <= 8'h_00;
            cmp_hi_r <= 8'h_00;
            ecomp_r <= 1'b0;
        end else begin
            if (wr_lo) begin
                cmp_lo_r <= wdata;
                ecomp_r <= 1'b0;
            end
            if (wr_hi) begin
                cmp_hi_r <= wdata;
                ecomp_r <= 1'b1;
            end
        end
    end

    // Duty holding register reloads at each period restart
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            duty_r <= 8'h_00;
        end else if (cnt.tick && cnt.prd_hit) begin
            duty_r <= cmp_hi_r;
        end
    end

    // Threshold per mode; ten bit ignores upper six bits of high byte
    always_comb begin
        case (cap_pkg::cap_pwm_t'(pwm_mode))
            cap_pkg::CAP_PWM_PROG: hit = cnt.cnt[7:0] >= duty_r;
            cap_pkg::CAP_PWM_WIDE: begin
                if (cnt.ten) begin
                    hit = (cnt.cnt & cap_pkg::TEN_MASK) >= (cmp16 & cap_pkg::TEN_MASK);
                end else begin
                    hit = cnt.cnt >= cmp16;
                end
            end
            default: hit = 1'b0;
        endcase
    end

    // Registered threshold; a wrap or restart lowers it through the count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= 1'b0;
        end else if (!ecomp_r) begin
            out_r <= 1'b0;
        end else begin
            out_r <= hit;
        end
    end
endmodule : cap_module
`default_nettype wire

// *** core/cap_block.sv ***
// Counter array block 0: shared counter, period register, three PWM modules.
// Assumes a synchronous byte-wide SFR port; one access per cycle.
`default_nettype none
module cap_block #(
    parameter int NMOD = 3
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    input wire logic PRESC_TICK,
    input wire logic T0_OVF,
    input wire logic EXT_CLK,
    input wire logic OVF_FLAG_BLOCK1_SET,
    output logic START_ALL,
    output logic IRQ,
    output logic [NMOD-1:0] PWM_OUT_PIN
);
    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_s1_r;
    logic rst_n;

    // Two stage release keeps deassertion synchronous
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    cap_pkg::cap_req_t req;
    cap_pkg::cap_cnt_t cs;
    logic [7:0] ctrl_r;
    logic [7:0] period_r;
    logic [7:0] period_hold_r;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [7:0] status_r;
    logic [7:0] mode_r [NMOD];
    logic [7:0] rdata_r;
    logic run;
    logic tick;
    logic [NMOD-1:0] prog_any;
    logic [7:0] cmp_lo [NMOD];
    logic [7:0] cmp_hi [NMOD];
    logic [NMOD-1:0] ecomp;
    logic [NMOD-1:0] wr_lo;
    logic [NMOD-1:0] wr_hi;

    assign req = '{addr: SFR_ADDR, wdata: SFR_WDATA, wr: SFR_WR, rd: SFR_RD};

    // Control register; bit 3 is reserved and stays zero
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= cap_pkg::CTRL_RESET;
        end else if (req.wr && req.addr == cap_pkg::CTRL0_OFF) begin
            ctrl_r <= req.wdata & cap_pkg::CTRL_WMASK;
        end
    end

    // Period register written by software; holding copy used by compare
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            period_r <= 8'h_00;
        end else if (req.wr && req.addr == cap_pkg::PERIOD_OFF) begin
            period_r <= req.wdata;
        end
    end

    // Holding copy reloads on each match so a new period lands cleanly
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            period_hold_r <= 8'h_00;
        end else if (!run || (tick && cs.prd_hit)) begin
            period_hold_r <= period_r;
        end
    end

    // Mode registers, one per module
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NMOD; i++) begin
                mode_r[i] <= cap_pkg::MODE_RESET;
            end
        end else begin
            for (int i = 0; i < NMOD; i++) begin
                if (req.wr && req.addr == cap_pkg::MODE0_OFF + 8'(i)) begin
                    mode_r[i] <= req.wdata;
                end
            end
        end
    end

    // Compare write strobes
    always_comb begin
        wr_lo[0] = req.wr && req.addr == cap_pkg::CMP_LO0_OFF;
        wr_hi[0] = req.wr && req.addr == cap_pkg::CMP_HI0_OFF;
        wr_lo[1] = req.wr && req.addr == cap_pkg::CMP_LO1_OFF;
        wr_hi[1] = req.wr && req.addr == cap_pkg::CMP_HI1_OFF;
        wr_lo[2] = req.wr && req.addr == cap_pkg::CMP_LO2_OFF;
        wr_hi[2] = req.wr && req.addr == cap_pkg::CMP_HI2_OFF;
    end

    // ****************************************************************
    // Counter
    // ****************************************************************
    // Global start overrides the individual run bit
    assign run = ctrl_r[cap_pkg::CTRL_EN_ALL_BIT] | ctrl_r[cap_pkg::CTRL_RUN_BIT];
    assign START_ALL = ctrl_r[cap_pkg::CTRL_EN_ALL_BIT];

    cap_tick_sel u_tick (
        .clk(CLK),
        .rst_n(rst_n),
        .run(run),
        .sel(ctrl_r[1:0]),
        .presc_tick(PRESC_TICK),
        .t0_ovf(T0_OVF),
        .ext_clk(EXT_CLK),
        .tick(tick)
    );

    always_comb begin
        for (int i = 0; i < NMOD; i++) begin
            prog_any[i] = mode_r[i][1:0] == cap_pkg::CAP_PWM_PROG;
        end
    end

    // Strobes shared by all modules
    always_comb begin
        cs.tick = tick;
        cs.ten = ctrl_r[cap_pkg::CTRL_TEN_BIT];
        cs.cnt = cnt_r;
        cs.prd_hit = (|prog_any) && cnt_r[7:0] == period_hold_r;
        if (cs.ten) begin
            cs.wrap = (cnt_r & cap_pkg::TEN_MASK) == cap_pkg::TEN_MASK;
        end else begin
            cs.wrap = cnt_r == 16'h_ffff;
        end
    end

    // Next count: match clears, ten bit wraps at 1023
    always_comb begin
        if (cs.prd_hit) begin
            cnt_nxt = 16'h_0000;
        end else if (cs.ten && cs.wrap) begin
            cnt_nxt = 16'h_0000;
        end else begin
            cnt_nxt = cnt_r + 16'h_0001;
        end
    end

    // Counter bytes are also software writable
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 16'h_0000;
        end else if (req.wr && req.addr == cap_pkg::CNT_LO_OFF) begin
            cnt_r[7:0] <= req.wdata;
        end else if (req.wr && req.addr == cap_pkg::CNT_HI_OFF) begin
            cnt_r[15:8] <= req.wdata;
        end else if (tick) begin
            cnt_r <= cnt_nxt;
        end
    end

    // ****************************************************************
    // Status and interrupt
    // ****************************************************************
    // Hardware set beats a software clear in the same cycle
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= cap_pkg::STATUS_RESET;
        end else begin
            if (req.wr && req.addr == cap_pkg::STATUS_OFF) begin
                status_r <= req.wdata;
            end
            if (tick && cs.wrap) begin
                status_r[cap_pkg::STAT_OVERFLOW_FLAG_BLOCK0_BIT] <= 1'b1;
            end
            if (OVF_FLAG_BLOCK1_SET) begin
                status_r[7] <= 1'b1;
            end
        end
    end

    assign IRQ = status_r[cap_pkg::STAT_OVERFLOW_FLAG_BLOCK0_BIT] & ctrl_r[cap_pkg::CTRL_OVF_IE_BIT];

    // ****************************************************************
    // Modules
    // ****************************************************************
    for (genvar g = 0; g < NMOD; g++) begin : g_mod
        cap_module u_mod (
            .clk(CLK),
            .rst_n(rst_n),
            .cnt(cs),
            .pwm_mode(mode_r[g][1:0]),
            .wr_lo(wr_lo[g]),
            .wr_hi(wr_hi[g]),
            .wdata(req.wdata),
            .cmp_lo(cmp_lo[g]),
            .cmp_hi(cmp_hi[g]),
            .ecomp(ecomp[g]),
            .pwm_out(PWM_OUT_PIN[g])
        );
    end

    // ****************************************************************
    // Read back
    // ****************************************************************
    // Mode reads show live compare enable in bit 6
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h_00;
        end else if (req.rd) begin
            case (req.addr)
                cap_pkg::CTRL0_OFF: rdata_r <= ctrl_r;
                cap_pkg::CNT_LO_OFF: rdata_r <= cnt_r[7:0];
                cap_pkg::CNT_HI_OFF: rdata_r <= cnt_r[15:8];
                cap_pkg::STATUS_OFF: rdata_r <= status_r;
                cap_pkg::PERIOD_OFF: rdata_r <= period_r;
                cap_pkg::CMP_LO0_OFF: rdata_r <= cmp_lo[0];
                cap_pkg::CMP_HI0_OFF: rdata_r <= cmp_hi[0];
                cap_pkg::CMP_LO1_OFF: rdata_r <= cmp_lo[1];
                cap_pkg::CMP_HI1_OFF: rdata_r <= cmp_hi[1];
                cap_pkg::CMP_LO2_OFF: rdata_r <= cmp_lo[2];
                cap_pkg::CMP_HI2_OFF: rdata_r <= cmp_hi[2];
                cap_pkg::MODE0_OFF: rdata_r <= {mode_r[0][7], ecomp[0], mode_r[0][5:0]};
                cap_pkg::MODE0_OFF + 8'h_01: rdata_r <= {mode_r[1][7], ecomp[1], mode_r[1][5:0]};
                cap_pkg::MODE0_OFF + 8'h_02: rdata_r <= {mode_r[2][7], ecomp[2], mode_r[2][5:0]};
                default: rdata_r <= 8'h_00;
            endcase
        end
    end

    assign SFR_RDATA = rdata_r;
endmodule : cap_block
`default_nettype wire

// *** test/cap_block_monitor.sv ***
// Port-level checker for the counter array PWM block.
// Assumes one clock domain and at most one register access per cycle.
`default_nettype none
module cap_block_monitor #(
    parameter int NMOD = 3
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    input wire logic START_ALL,
    input wire logic IRQ,
    input wire logic [NMOD-1:0] PWM_OUT_PIN
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Shadow state
    // ****************
    logic [7:0] ctrl_r;
    logic [NMOD-1:0] ecomp_r;
    logic [2:0] quiet_r;
    logic [7:0] mode_idx;
    logic wr_ctrl;
    logic rd_mode;
    logic ec_sel;
    // Decoded accesses; index valid only with rd_mode
    assign wr_ctrl = SFR_WR && (SFR_ADDR == cap_pkg::CTRL0_OFF);
    assign mode_idx = SFR_ADDR - cap_pkg::MODE0_OFF;
    assign rd_mode = SFR_RD && (mode_idx < 8'h_03);
    assign ec_sel = ecomp_r[mode_idx[1:0]];
    // Control shadow, masked like the real register
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_r <= cap_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= SFR_WDATA & cap_pkg::CTRL_WMASK;
        end
    end
    // Compare enables from compare writes
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ecomp_r <= '0;
        end else if (SFR_WR) begin
            case (SFR_ADDR)
                cap_pkg::CMP_LO0_OFF: ecomp_r[0] <= 1'h_0;
                cap_pkg::CMP_HI0_OFF: ecomp_r[0] <= 1'h_1;
                cap_pkg::CMP_LO1_OFF: ecomp_r[1] <= 1'h_0;
                cap_pkg::CMP_HI1_OFF: ecomp_r[1] <= 1'h_1;
                cap_pkg::CMP_LO2_OFF: ecomp_r[2] <= 1'h_0;
                cap_pkg::CMP_HI2_OFF: ecomp_r[2] <= 1'h_1;
                default: ecomp_r <= ecomp_r;
            endcase
        end
    end
    // Quiet cycles: counter stopped, no write; saturates so it never wraps
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            quiet_r <= 3'h_0;
        end else if (SFR_WR || ctrl_r[cap_pkg::CTRL_EN_ALL_BIT]
            || ctrl_r[cap_pkg::CTRL_RUN_BIT]) begin
            quiet_r <= 3'h_0;
        end else if (quiet_r != 3'h_7) begin
            quiet_r <= quiet_r + 3'h_1;
        end
    end
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    a_start_all_follows: assert property (wr_ctrl |=> START_ALL == $past(SFR_WDATA[7]))
        else $error("start-all not following bit 7");
    a_start_all_cause: assert property ($changed(START_ALL) |-> $past(wr_ctrl))
        else $error("start-all moved without a write");
    a_irq_needs_enable: assert property (IRQ |-> ctrl_r[cap_pkg::CTRL_OVF_IE_BIT])
        else $error("interrupt while enable clear");
    a_irq_clear_next: assert property (wr_ctrl && !SFR_WDATA[5] |=> !IRQ)
        else $error("interrupt still high after enable cleared");
    a_ctrl_read_back: assert property (SFR_RD && SFR_ADDR == cap_pkg::CTRL0_OFF
        |=> SFR_RDATA == $past(ctrl_r))
        else $error("control read back wrong");
    a_ecomp_read_back: assert property (rd_mode |=> SFR_RDATA[6] == $past(ec_sel))
        else $error("compare enable read back wrong");
    a_disabled_stays_low: assert property (
        (PWM_OUT_PIN & ~ecomp_r & ~$past(ecomp_r) & ~$past(ecomp_r, 2)) == '0)
        else $error("output high while disabled");
    a_stopped_outputs_hold: assert property (quiet_r >= 3'h_4 |-> $stable(PWM_OUT_PIN))
        else $error("output moved while counter stopped");
    c_irq: cover property (IRQ);
    c_start_all: cover property ($rose(START_ALL));
    c_pwm_rise: cover property ($rose(PWM_OUT_PIN[0]));
    c_quiet: cover property (quiet_r == 3'h_7);
endmodule : cap_block_monitor
bind cap_block cap_block_monitor #(.NMOD(NMOD)) u_mon (
    .CLK(CLK),
    .RST_B(RST_B),
    .SFR_ADDR(SFR_ADDR),
    .SFR_WDATA(SFR_WDATA),
    .SFR_WR(SFR_WR),
    .SFR_RD(SFR_RD),
    .SFR_RDATA(SFR_RDATA),
    .START_ALL(START_ALL),
    .IRQ(IRQ),
    .PWM_OUT_PIN(PWM_OUT_PIN)
);
`default_nettype wire

// *** test/cap_cpu_model.sv ***
// CPU software model driving the register port of the PWM block.
// Assumes the bench calls its tasks; one access at a time.
`default_nettype none
module cap_cpu_model (
    input wire logic clk,
    input wire logic [7:0] sfr_rdata,
    output logic [7:0] sfr_addr,
    output logic [7:0] sfr_wdata,
    output logic sfr_wr,
    output logic sfr_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // Bus cycles
    // ****************
    // Idle values at time zero
    initial begin
        sfr_addr = 8'h_00;
        sfr_wdata = 8'h_00;
        sfr_wr = 1'h_0;
        sfr_rd = 1'h_0;
    end
    // Released lines are inverted so stale values cannot pass for valid ones
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'h_1;
        @(posedge clk);
        sfr_wr <= 1'h_0;
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
    endtask : sfr_write
    // Read data lands on the same edge that takes the strobe
    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'h_1;
        @(posedge clk);
        sfr_rd <= 1'h_0;
        sfr_addr <= ~a;
        #1;
        d = sfr_rdata;
    endtask : sfr_read
    // Same PWM mode in every module of the block
    task automatic set_modes(input logic [1:0] m);
        for (int i = 0; i < 3; i++) begin
            sfr_write(cap_pkg::MODE0_OFF + 8'(i), {6'h_00, m});
        end
    endtask : set_modes
    // Compare pair of one module, low byte first
    task automatic write_cmp(input int m, input logic [7:0] hi, input logic [7:0] lo);
        logic [7:0] lo_a;
        logic [7:0] hi_a;
        lo_a = m == 0 ? cap_pkg::CMP_LO0_OFF :
            m == 1 ? cap_pkg::CMP_LO1_OFF : cap_pkg::CMP_LO2_OFF;
        hi_a = m == 0 ? cap_pkg::CMP_HI0_OFF :
            m == 1 ? cap_pkg::CMP_HI1_OFF : cap_pkg::CMP_HI2_OFF;
        sfr_write(lo_a, lo);
        sfr_write(hi_a, hi);
    endtask : write_cmp
endmodule : cap_cpu_model
`default_nettype wire

// *** test/counter_array_pwm_modes_bench.sv ***
// Self-checking bench for the counter array PWM block.
// Assumes the CPU model for register access and a 100 MHz clock.
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch %s expected %0h seen %0h", nm, exp, got); end end
module counter_array_pwm_modes_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, sfr_wr, sfr_rd, presc, t0_ovf, ext_clk, overflow_flag_block1, start_all, irq;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, va, vb;
    logic [2:0] pwm;
    int error_cnt = 0;
    int check_count = 0;
    int hi_cnt [3];
    // ****************
    // Harness
    // ****************
    cap_block #(.NMOD(3)) u_dut (.CLK(clk), .RST_B(rst_b), .SFR_ADDR(sfr_addr),
        .SFR_WDATA(sfr_wdata), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata),
        .PRESC_TICK(presc), .T0_OVF(t0_ovf), .EXT_CLK(ext_clk), .OVF_FLAG_BLOCK1_SET(overflow_flag_block1),
        .START_ALL(start_all), .IRQ(irq), .PWM_OUT_PIN(pwm));
    cap_cpu_model u_cpu (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd));
    initial begin
        clk = 1'h_0;
        forever #5 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    // High cycles of each pin over a window
    task automatic count_high(input int win);
        hi_cnt = '{0, 0, 0};
        repeat (win) begin
            @(posedge clk);
            #1;
            for (int i = 0; i < 3; i++) hi_cnt[i] += int'(pwm[i] === 1'h_1);
        end
    endtask : count_high
    // Counter low byte advance
    task automatic cnt_delta(input logic [7:0] ctrl, input int gap, input logic [7:0] exp);
        u_cpu.sfr_write(cap_pkg::CTRL0_OFF, ctrl);
        u_cpu.sfr_read(cap_pkg::CNT_LO_OFF, va);
        if (ctrl[1:0] == 2'h_1) begin
            repeat (gap) begin @(posedge clk); t0_ovf <= 1'h_1; @(posedge clk); t0_ovf <= 1'h_0; end
        end else if (ctrl[1:0] == 2'h_2) begin
            repeat (gap) begin repeat (3) @(posedge clk); ext_clk <= ~ext_clk; end
        end else begin
            repeat (gap) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        u_cpu.sfr_read(cap_pkg::CNT_LO_OFF, vb);
        `CHK("count step", exp, 8'(vb - va))
    endtask : cnt_delta
    // ****************
    // Scenarios
    // ****************
    task automatic test_regs;
        u_cpu.sfr_read(cap_pkg::CTRL0_OFF, va);
        `CHK("ctrl reset", cap_pkg::CTRL_RESET, va)
        u_cpu.sfr_read(8'h_a0, va);
        `CHK("unmapped", 8'h_00, va)
        u_cpu.sfr_write(cap_pkg::CTRL0_OFF, 8'h_3f);
        u_cpu.sfr_read(cap_pkg::CTRL0_OFF, va);
        `CHK("ctrl fields", 8'h_37, va)
        u_cpu.sfr_write(cap_pkg::STATUS_OFF, 8'h_08);
        repeat (2) @(posedge clk);
        `CHK("irq on", 1'h_1, irq)
        u_cpu.sfr_write(cap_pkg::CTRL0_OFF, 8'h_13);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'h_0, irq)
        u_cpu.sfr_write(cap_pkg::STATUS_OFF, 8'h_00);
        @(posedge clk);
        overflow_flag_block1 <= 1'h_1;
        @(posedge clk);
        overflow_flag_block1 <= 1'h_0;
        u_cpu.sfr_read(cap_pkg::STATUS_OFF, va);
        `CHK("block1 flag", 8'h_80, va)
        u_cpu.sfr_write(cap_pkg::STATUS_OFF, 8'h_00);
        $display("done test_regs");
    endtask : test_regs
    task automatic test_clock_sel;
        cnt_delta(8'h_00, 6, 8'h_00);
        cnt_delta(8'h_40, 6, 8'h_0e);
        cnt_delta(8'h_41, 3, 8'h_03);
        cnt_delta(8'h_42, 8, 8'h_04);
        cnt_delta(8'h_80, 6, 8'h_0e);
        `CHK("start all", 1'h_1, start_all)
        u_cpu.sfr_write(cap_pkg::CTRL0_OFF, 8'h_00);
        $display("done test_clock_sel");
    endtask : test_clock_sel
    task automatic test_prog;
        u_cpu.set_modes(cap_pkg::CAP_PWM_PROG);
        u_cpu.sfr_write(cap_pkg::PERIOD_OFF, 8'h_09);
        u_cpu.write_cmp(0, 8'h_03, 8'h_00);
        u_cpu.write_cmp(1, 8'h_05, 8'h_00);
        u_cpu.write_cmp(2, 8'h_08, 8'h_00);
        u_cpu.sfr_read(cap_pkg::MODE0_OFF, va);
        `CHK("ecomp set", 1'h_1, va[cap_pkg::MODE_ECOMP_BIT])
        u_cpu.sfr_write(cap_pkg::CTRL0_OFF, 8'h_40);
        repeat (300) @(posedge clk);
        count_high(50);
        `CHK("prog 0", 35, hi_cnt[0])
        `CHK("prog 1", 25, hi_cnt[1])
        `CHK("prog 2", 10, hi_cnt[2])
        $display("done test_prog");
    endtask : test_prog
    task automatic test_ten;
        u_cpu.sfr_write(cap_pkg::CTRL0_OFF, 8'h_04);
        u_cpu.set_modes(cap_pkg::CAP_PWM_WIDE);
        u_cpu.write_cmp(0, 8'h_fe, 8'h_00);
        u_cpu.write_cmp(1, 8'h_03, 8'h_00);
        u_cpu.write_cmp(2, 8'h_fc, 8'h_80);
        u_cpu.sfr_write(cap_pkg::CTRL0_OFF, 8'h_44);
        repeat (1100) @(posedge clk);
        count_high(1024);
        `CHK("ten 0", 512, hi_cnt[0])
        `CHK("ten 1", 256, hi_cnt[1])
        `CHK("ten 2", 896, hi_cnt[2])
        $display("done test_ten");
    endtask : test_ten
    task automatic test_sixteen;
        logic [7:0] hi_t [4] = '{8'h_ff, 8'h_ff, 8'h_00, 8'h_ff};
        logic [7:0] lo_t [4] = '{8'h_f8, 8'h_ff, 8'h_00, 8'h_f8};
        int exp_t [4] = '{8, 1, 40, 0};
        u_cpu.sfr_write(cap_pkg::CTRL0_OFF, 8'h_00);
        u_cpu.set_modes(cap_pkg::CAP_PWM_WIDE);
        for (int k = 0; k < 4; k++) begin
            u_cpu.sfr_write(cap_pkg::CTRL0_OFF, 8'h_00);
            u_cpu.sfr_write(cap_pkg::CNT_LO_OFF, 8'h_f0);
            u_cpu.sfr_write(cap_pkg::CNT_HI_OFF, 8'h_ff);
            for (int m = 0; m < 3; m++) u_cpu.write_cmp(m, hi_t[k], lo_t[k]);
            if (k == 3) begin
                u_cpu.sfr_write(cap_pkg::CMP_LO0_OFF, 8'h_f8);
                u_cpu.sfr_write(cap_pkg::CMP_LO1_OFF, 8'h_f8);
                u_cpu.sfr_write(cap_pkg::CMP_LO2_OFF, 8'h_f8);
                u_cpu.sfr_read(cap_pkg::MODE0_OFF, va);
                `CHK("ecomp clear", 1'h_0, va[cap_pkg::MODE_ECOMP_BIT])
            end
            u_cpu.sfr_write(cap_pkg::CTRL0_OFF, 8'h_40);
            repeat (4) @(posedge clk);
            count_high(40);
            for (int m = 0; m < 3; m++) `CHK("wide duty", exp_t[k], hi_cnt[m])
        end
        u_cpu.sfr_read(cap_pkg::STATUS_OFF, va);
        `CHK("wrap flag", 1'h_1, va[cap_pkg::STAT_OVERFLOW_FLAG_BLOCK0_BIT])
        `CHK("irq off", 1'h_0, irq)
        $display("done test_sixteen");
    endtask : test_sixteen
    // ****************
    // Sequence
    // ****************
    initial begin
        rst_b = 1'h_0;
        presc = 1'h_1;
        t0_ovf = 1'h_0;
        ext_clk = 1'h_0;
        overflow_flag_block1 = 1'h_0;
        repeat (5) @(posedge clk);
        rst_b <= 1'h_1;
        repeat (5) @(posedge clk);
        test_regs();
        test_clock_sel();
        test_prog();
        test_ten();
        test_sixteen();
        give_verdict();
    end
    // Watchdog; the tests need a few thousand cycles
    initial begin
        #200000;
        error_cnt++;
        give_verdict();
    end
endmodule : counter_array_pwm_modes_bench
`default_nettype wire
